// file: rtl/ivq_top.sv
// Purpose: eight-channel input voltage qualifier with an APB register file
// Assumes: meas_mv comes from a converter clocked by pclk, so no resync
// Notes: zero-wait APB, pready raised in each access phase
module ivq_top
    import ivq_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCH-1:0][18:0] meas_mv,
    output logic [NCH-1:0] qual_state
);
    // ==========================================================
    // state and reset values
    ivq_regs_t r_reg;
    ivq_regs_t r_next;
    logic [NCH-1:0] energ;
    logic [NCH-1:0][31:0] cnt;
    logic [2:0] a_ch;
    logic [4:0] a_ofs;
    logic a_chan;
    logic a_all;
    logic a_ok;
    logic setup;
    logic commit;

    assign a_ch = paddr[7:5];
    assign a_ofs = paddr[4:0];
    assign a_chan = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0);
    assign a_all = (paddr == OFS_ALL_STATE);
    assign a_ok = a_chan || a_all;
    assign setup = psel && !penable;
    assign commit = psel && penable && r_reg.pready && pwrite && !r_reg.pslverr;

    // ==========================================================
    // helpers
    function automatic logic [10:0] clamp_thr(input logic [31:0] v, input logic [10:0] lo);
        logic [10:0] res;
        if (v < 32'(lo)) begin
            res = lo;
        end else if (v > 32'(THR_MAX)) begin
            res = THR_MAX;
        end else begin
            res = v[10:0];
        end
        return res;
    endfunction : clamp_thr

    function automatic logic [20:0] clamp_dly(input logic [31:0] v);
        logic [20:0] res;
        if (v > 32'(DLY_MAX)) begin
            res = DLY_MAX;
        end else begin
            res = v[20:0];
        end
        return res;
    endfunction : clamp_dly

    // ==========================================================
    // next state
    always_comb begin
        r_next = r_reg;
        r_next.clr = '0;
        r_next.ms_en = 1'b0;
        r_next.scan_en = 1'b0;
        // single clock: millisecond and scan rates are enable pulses
        if (r_reg.ms_cnt == 16'(MS_CYCLES - 1)) begin
            r_next.ms_cnt = '0;
            r_next.ms_en = 1'b1;
        end else begin
            r_next.ms_cnt = r_reg.ms_cnt + 16'h1;
        end
        if (r_reg.ms_en) begin
            if (r_reg.scan_cnt == SCAN_MS - 3'h1) begin
                r_next.scan_cnt = '0;
                r_next.scan_en = 1'b1;
            end else begin
                r_next.scan_cnt = r_reg.scan_cnt + 3'h1;
            end
        end
        // read data and error are prepared in the setup cycle
        r_next.pready = setup;
        r_next.pslverr = setup && !a_ok;
        r_next.prdata = '0;
        if (setup && !pwrite && a_all) begin
            r_next.prdata = 32'(qual_state);
        end else if (setup && !pwrite && a_chan) begin
            case (a_ofs)
                OFS_CFG: r_next.prdata = {30'h0, r_reg.ac[a_ch], r_reg.pol[a_ch]};
                OFS_ACT_THR: r_next.prdata = 32'(r_reg.act_thr[a_ch]);
                OFS_REL_THR: r_next.prdata = 32'(r_reg.rel_thr[a_ch]);
                OFS_ACT_DLY: r_next.prdata = 32'(r_reg.act_dly[a_ch]);
                OFS_DROP_DLY: r_next.prdata = 32'(r_reg.drop_dly[a_ch]);
                OFS_COUNT: r_next.prdata = cnt[a_ch];
                OFS_VOLT: r_next.prdata = 32'(meas_mv[a_ch]);
                OFS_STATUS: r_next.prdata = {30'h0, energ[a_ch], qual_state[a_ch]};
                default: r_next.prdata = '0;
            endcase
        end
        if (commit && a_chan) begin
            case (a_ofs)
                OFS_CFG: begin
                    r_next.pol[a_ch] = pwdata[CFG_POL_BIT];
                    r_next.ac[a_ch] = pwdata[CFG_AC_BIT];
                end
                OFS_ACT_THR: r_next.act_thr[a_ch] = clamp_thr(pwdata, ACT_THR_MIN);
                OFS_REL_THR: r_next.rel_thr[a_ch] = clamp_thr(pwdata, REL_THR_MIN);
                OFS_ACT_DLY: r_next.act_dly[a_ch] = clamp_dly(pwdata);
                OFS_DROP_DLY: r_next.drop_dly[a_ch] = clamp_dly(pwdata);
                OFS_COUNT: r_next.clr[a_ch] = pwdata[CLR_BIT];
                default: r_next.clr = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // constants only in the reset branch
            r_reg <= '0;
            r_reg.act_thr <= {NCH{ACT_THR_RST}};
            r_reg.rel_thr <= {NCH{REL_THR_RST}};
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;

    // ==========================================================
    // channels
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        ivq_chan u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .ms_en(r_reg.ms_en),
            .scan_en(r_reg.scan_en),
            .meas_mv(meas_mv[g]),
            .polarity(r_reg.pol[g]),
            .alternating_supply_option(r_reg.ac[g]),
            .act_thr(r_reg.act_thr[g]),
            .rel_thr(r_reg.rel_thr[g]),
            .act_dly(r_reg.act_dly[g]),
            .deactivation_delay(r_reg.drop_dly[g]),
            .count_clear_command(r_reg.clr[g]),
            .qual_state(qual_state[g]),
            .energized(energ[g]),
            .rise_transition_count(cnt[g])
        );
    end

    // ==========================================================
    // checks
    property p_thr_range;
        @(posedge pclk) disable iff (!presetn)
        r_reg.act_thr[0] >= ACT_THR_MIN && r_reg.act_thr[0] <= THR_MAX
        && r_reg.rel_thr[0] >= REL_THR_MIN && r_reg.rel_thr[0] <= THR_MAX;
    endproperty
    a_thr_range: assert property (p_thr_range)
        else $error("threshold out of range");

    property p_scan_gap;
        @(posedge pclk) disable iff (!presetn)
        r_reg.scan_en |=> !r_reg.scan_en [*8];
    endproperty
    a_scan_gap: assert property (p_scan_gap)
        else $error("scan pulses too close");

    property p_scan_on_ms;
        @(posedge pclk) disable iff (!presetn)
        r_reg.scan_en |-> $past(r_reg.ms_en) && $past(r_reg.scan_cnt) == SCAN_MS - 3'h1;
    endproperty
    a_scan_on_ms: assert property (p_scan_on_ms)
        else $error("scan not on fifth millisecond");

    property p_volt_read;
        @(posedge pclk) disable iff (!presetn)
        setup && !pwrite && a_chan && a_ofs == OFS_VOLT
        |=> prdata == 32'($past(meas_mv[a_ch])) && pready;
    endproperty
    a_volt_read: assert property (p_volt_read)
        else $error("voltage read mismatch");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        commit && a_chan && a_ofs == OFS_COUNT && pwdata[CLR_BIT] && a_ch == 3'h0
        |=> ##1 cnt[0] == ($rose(qual_state[0]) ? 32'h1 : 32'h0);
    endproperty
    a_clear: assert property (p_clear)
        else $error("count clear lost");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        setup && !a_ok |=> pslverr && pready && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address not refused");

    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held past one cycle");

    property p_idle_zero;
        @(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0 && !pslverr;
    endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("read data or error outside access phase");

    property p_cfg_write;
        @(posedge pclk) disable iff (!presetn)
        commit && a_chan && a_ofs == OFS_CFG
        |=> r_reg.pol[$past(a_ch)] == $past(pwdata[CFG_POL_BIT])
            && r_reg.ac[$past(a_ch)] == $past(pwdata[CFG_AC_BIT]);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("configuration write lost");

    c_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(qual_state[0]));
    c_fall: cover property (@(posedge pclk) disable iff (!presetn) $fell(qual_state[0]));
    c_clear: cover property (@(posedge pclk) disable iff (!presetn) r_reg.clr[0]);
    c_write: cover property (@(posedge pclk) disable iff (!presetn) commit);
    c_ac_drop: cover property (@(posedge pclk) disable iff (!presetn)
        r_reg.ac[3] && $fell(qual_state[3]));
endmodule : ivq_top

// file: rtl/ivq_pkg.sv
// Purpose: constants and types for the eight-channel input voltage qualifier
// Assumes: pclk at 40 MHz, voltages arrive as millivolt words on the pclk domain
// Notes: thresholds are held in 0.1 V steps, delays in 1 ms steps
// Notes on behaviour
// - each channel picks normally-open or normally-closed, which sets whether energized reads 1 or 0, default normally-open.
// - each channel holds an activation threshold of 16.0 to 200.0 V in 0.1 V steps, default 88 V.
// - normally-open channels activate when the voltage rises above the activation threshold.
// - normally-closed channels deactivate when the voltage rises above the activation threshold.
// - each channel holds a release threshold of 10.0 to 200.0 V in 0.1 V steps, default 60 V.
// - normally-open channels deactivate when the voltage falls below the release threshold.
// - normally-closed channels activate when the voltage falls below the release threshold.
// - a 0-to-1 change waits for the channel's activation delay, up to 1800 s in 1 ms steps, default 0.
// - a 1-to-0 change waits for the channel's drop-off time, up to 1800 s in 1 ms steps, default 0.
// - with AC mode on, a further 30 ms is added to deactivation; AC mode is off by default.
// - with AC mode on, the release level is 10 percent of the activation threshold.
// - each channel counts its 0-to-1 changes in 32 bits starting from zero.
// - the clear command sets that channel's count back to zero.
// - the measured voltage of every channel, 0 to 275 V at 1 mV, is readable.
// - eight channels, each evaluated once per 5 ms program cycle.
package ivq_pkg;
    localparam int NCH = 8;
    localparam int CLK_HZ = 40000000;
    localparam int MS_PER_SEC = 1000;
    localparam int MS_CYC = CLK_HZ / MS_PER_SEC;
    localparam logic [2:0] SCAN_MS = 3'h5;
    localparam logic [20:0] AC_EXTRA_MS = 21'h0001E;
    localparam logic [20:0] DLY_MAX = 21'h1B7740;
    localparam logic [10:0] ACT_THR_MIN = 11'h0A0;
    localparam logic [10:0] REL_THR_MIN = 11'h064;
    localparam logic [10:0] THR_MAX = 11'h7D0;
    localparam logic [10:0] ACT_THR_RST = 11'h370;
    localparam logic [10:0] REL_THR_RST = 11'h258;
    localparam logic [18:0] MV_PER_STEP = 19'h00064;
    localparam logic [18:0] AC_REL_DIV = 19'h0000A;
    // register map: channel n at n*0x20, one word each
    localparam logic [4:0] OFS_CFG = 5'h00;
    localparam logic [4:0] OFS_ACT_THR = 5'h04;
    localparam logic [4:0] OFS_REL_THR = 5'h08;
    localparam logic [4:0] OFS_ACT_DLY = 5'h0C;
    localparam logic [4:0] OFS_DROP_DLY = 5'h10;
    localparam logic [4:0] OFS_COUNT = 5'h14;
    localparam logic [4:0] OFS_VOLT = 5'h18;
    localparam logic [4:0] OFS_STATUS = 5'h1C;
    localparam logic [11:0] OFS_ALL_STATE = 12'h100;
    localparam int CFG_POL_BIT = 0;
    localparam int CFG_AC_BIT = 1;
    localparam int CLR_BIT = 0;

    typedef struct packed {
        logic energ;
        logic state;
        logic [20:0] dly_cnt;
        logic [31:0] count;
    } ivq_chan_t;

    typedef struct packed {
        logic [NCH-1:0] pol;
        logic [NCH-1:0] ac;
        logic [NCH-1:0][10:0] act_thr;
        logic [NCH-1:0][10:0] rel_thr;
        logic [NCH-1:0][20:0] act_dly;
        logic [NCH-1:0][20:0] drop_dly;
        logic [NCH-1:0] clr;
        logic [15:0] ms_cnt;
        logic [2:0] scan_cnt;
        logic ms_en;
        logic scan_en;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ivq_regs_t;
endpackage : ivq_pkg

// file: rtl/ivq_chan.sv
// Purpose: one channel: threshold hysteresis, polarity, delays, rise counter
// Assumes: ms_en and scan_en are one-cycle pulses from the shared time base
// Notes: energized level only moves on a scan pulse
module ivq_chan
    import ivq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ms_en,
    input wire logic scan_en,
    input wire logic [18:0] meas_mv,
    input wire logic polarity,
    input wire logic alternating_supply_option,
    input wire logic [10:0] act_thr,
    input wire logic [10:0] rel_thr,
    input wire logic [20:0] act_dly,
    input wire logic [20:0] deactivation_delay,
    input wire logic count_clear_command,
    output logic qual_state,
    output logic energized,
    output logic [31:0] rise_transition_count
);
    ivq_chan_t r_reg;
    ivq_chan_t r_next;
    logic [18:0] act_mv;
    logic [18:0] rel_mv;
    logic target;
    logic [20:0] req;
    logic rising;

    assign act_mv = 19'(act_thr) * MV_PER_STEP;
    // ac mode ignores the programmed release value
    assign rel_mv = alternating_supply_option ? act_mv / AC_REL_DIV
                                              : 19'(rel_thr) * MV_PER_STEP;
    assign target = polarity ? ~r_reg.energ : r_reg.energ;
    assign req = target ? act_dly
               : deactivation_delay + (alternating_supply_option ? AC_EXTRA_MS : 21'h0);
    assign rising = (target != r_reg.state) && (r_reg.dly_cnt >= req) && target;

    always_comb begin
        r_next = r_reg;
        if (scan_en) begin
            if (meas_mv > act_mv) begin
                r_next.energ = 1'b1;
            end else if (meas_mv < rel_mv) begin
                r_next.energ = 1'b0;
            end
        end
        if (target == r_reg.state) begin
            r_next.dly_cnt = '0;
        end else if (r_reg.dly_cnt >= req) begin
            r_next.state = target;
            r_next.dly_cnt = '0;
        end else if (ms_en) begin
            r_next.dly_cnt = r_reg.dly_cnt + 21'h1;
        end
        if (count_clear_command) begin
            r_next.count = '0;
        end
        // a rise in the clear cycle still counts
        // saturate, but a clear always makes room for the new rise
        if (rising && (count_clear_command || r_reg.count != 32'hFFFFFFFF)) begin
            r_next.count = (count_clear_command ? 32'h0 : r_reg.count) + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign qual_state = r_reg.state;
    assign energized = r_reg.energ;
    assign rise_transition_count = r_reg.count;

    property p_hold_between;
        @(posedge pclk) disable iff (!presetn)
        scan_en && meas_mv <= act_mv && meas_mv >= rel_mv |=> $stable(energized);
    endproperty
    a_hold_between: assert property (p_hold_between)
        else $error("energized level moved inside hysteresis band");

    property p_above_act;
        @(posedge pclk) disable iff (!presetn)
        scan_en && meas_mv > act_mv |=> energized;
    endproperty
    a_above_act: assert property (p_above_act)
        else $error("voltage above activation did not energize");

    property p_state_dir;
        @(posedge pclk) disable iff (!presetn)
        $changed(qual_state) |-> qual_state == ($past(polarity) ^ $past(energized));
    endproperty
    a_state_dir: assert property (p_state_dir)
        else $error("state changed against polarity");

    property p_fall_delay;
        @(posedge pclk) disable iff (!presetn)
        $fell(qual_state) |-> $past(r_reg.dly_cnt) >= $past(deactivation_delay)
            + ($past(alternating_supply_option) ? AC_EXTRA_MS : 21'h0);
    endproperty
    a_fall_delay: assert property (p_fall_delay)
        else $error("drop-off came early");

    property p_cancel;
        @(posedge pclk) disable iff (!presetn)
        target == qual_state |=> r_reg.dly_cnt == 21'h0;
    endproperty
    a_cancel: assert property (p_cancel)
        else $error("pending delay not cancelled");

    property p_count_rise;
        @(posedge pclk) disable iff (!presetn)
        $rose(qual_state) && !$past(count_clear_command) && $past(rise_transition_count) != '1
        |-> rise_transition_count == $past(rise_transition_count) + 32'h1;
    endproperty
    a_count_rise: assert property (p_count_rise)
        else $error("rise not counted");
endmodule : ivq_chan

// file: tb/ivq_field.sv
// Purpose: field wiring model, one applied voltage per input channel
// Assumes: the bench asks for a new level on one channel at a time
// Notes: levels beyond the measuring span are cut at 275 V
module ivq_field
    import ivq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic set_en,
    input wire logic [2:0] set_ch,
    input wire logic [18:0] set_mv,
    output logic [NCH-1:0][18:0] meas_mv
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // applied levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_mv <= '0;
        end else if (set_en) begin
            meas_mv[set_ch] <= (set_mv > 19'h43238) ? 19'h43238 : set_mv;
        end
    end
endmodule : ivq_field

// file: tb/tb_top.sv
// Purpose: self-checking bench for the eight-channel input qualifier
// Assumes: MS_CYCLES cut to 8 clocks, so one scan lasts 40 clocks
// Notes: random thresholds and levels mixed with hand-picked edge values
module tb_top
    import ivq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 8;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, set_en, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] set_ch;
    logic [18:0] set_mv;
    logic [NCH-1:0][18:0] meas_mv;
    logic [NCH-1:0] qual_state;
    int err_total = 0;
    int n_checks = 0;
    int el;

    always #12.5 pclk = ~pclk;

    ivq_top #(.MS_CYCLES(MSC)) ivq_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .meas_mv(meas_mv), .qual_state(qual_state));
    ivq_field ivq_field_i (.pclk(pclk), .presetn(presetn), .set_en(set_en), .set_ch(set_ch),
        .set_mv(set_mv), .meas_mv(meas_mv));

    // ==========================================================
    // expectations and reporting
    function automatic logic [31:0] clampv(logic [31:0] v, logic [31:0] lo, logic [31:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clampv

    function automatic logic exp_q(logic nc, logic energ);
        return nc ? ~energ : energ;
    endfunction : exp_q

    function automatic logic [11:0] ra(int ch, logic [4:0] o);
        return 12'(ch * 32) + {7'h00, o};
    endfunction : ra

    task automatic print_verdict();
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic chk_eq(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk_eq

    task automatic chk_rng(input string nm, input int lo, input int hi);
        n_checks++;
        if (el < lo || el > hi) begin
            err_total++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, el);
        end
    endtask : chk_rng

    // ==========================================================
    // bus and wiring drivers
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            chk_eq("pready", 32'h1, 32'h0);
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk_eq(nm, e, rd);
    endtask : rdchk

    task automatic drive_mv(input int ch, input logic [18:0] mv);
        @(posedge pclk);
        set_en <= 1'b1;
        set_ch <= 3'(ch);
        set_mv <= mv;
        @(posedge pclk);
        set_en <= 1'b0;
    endtask : drive_mv

    // bounded wait, el holds the clocks spent
    task automatic wait_q(input int ch, input logic v, input int lim);
        el = 0;
        while (qual_state[ch] !== v) begin
            @(posedge pclk);
            el++;
            if (el > lim) begin
                chk_eq("qual_state wait", 32'(v), 32'(qual_state[ch]));
                print_verdict();
            end
        end
    endtask : wait_q

    task automatic hold_q(input int ch, input logic v, input int ncyc);
        int bad;
        bad = 0;
        repeat (ncyc) begin
            @(posedge pclk);
            if (qual_state[ch] !== v) bad++;
        end
        chk_eq("qual_state hold", 32'h0, 32'(bad));
    endtask : hold_q

    // ==========================================================
    // main sequence
    initial begin
        int ch;
        logic [31:0] v;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        set_en = 1'b0;
        set_ch = 3'h0;
        set_mv = 19'h0;
        void'($urandom(32'h635E3F47));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (ch = 0; ch < NCH; ch++) begin
            rdchk("cfg", ra(ch, OFS_CFG), 32'h0);
            rdchk("act_thr", ra(ch, OFS_ACT_THR), 32'h370);
            rdchk("rel_thr", ra(ch, OFS_REL_THR), 32'h258);
            rdchk("act_dly", ra(ch, OFS_ACT_DLY), 32'h0);
            rdchk("drop_dly", ra(ch, OFS_DROP_DLY), 32'h0);
            rdchk("count", ra(ch, OFS_COUNT), 32'h0);
        end
        apb(1'b0, 12'h002, 32'h0);
        chk_eq("pslverr misaligned", 32'h1, {31'h0, er});
        apb(1'b0, 12'hFFC, 32'h0);
        chk_eq("pslverr unmapped", 32'h1, {31'h0, er});
        // first two values sit just outside the legal activation threshold span
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 32'h9F : ((i == 1) ? 32'h7D1 : ($urandom % 32'hA00));
            apb(1'b1, ra(7, OFS_ACT_THR), v);
            rdchk("act_thr clamp", ra(7, OFS_ACT_THR), clampv(v, 32'hA0, 32'h7D0));
            apb(1'b1, ra(7, OFS_REL_THR), v);
            rdchk("rel_thr clamp", ra(7, OFS_REL_THR), clampv(v, 32'h64, 32'h7D0));
        end
        for (int i = 0; i < 4; i++) begin
            v = $urandom % 32'h43239;
            drive_mv(7, 19'(v));
            repeat (5 * MSC + 4) @(posedge pclk);
            rdchk("volt", ra(7, OFS_VOLT), v);
        end
        drive_mv(0, 19'h157C0);
        hold_q(0, 1'b0, 100);
        drive_mv(0, 19'h157C1);
        wait_q(0, exp_q(1'b0, 1'b1), 60);
        drive_mv(0, 19'h11170);
        hold_q(0, 1'b1, 100);
        drive_mv(0, 19'h0EA60);
        hold_q(0, 1'b1, 100);
        drive_mv(0, 19'h0EA5F);
        wait_q(0, exp_q(1'b0, 1'b0), 60);
        drive_mv(0, 19'h15F90);
        wait_q(0, 1'b1, 60);
        rdchk("count", ra(0, OFS_COUNT), 32'h2);
        apb(1'b1, ra(0, OFS_COUNT), 32'h1);
        rdchk("count cleared", ra(0, OFS_COUNT), 32'h0);
        apb(1'b1, ra(1, OFS_CFG), 32'h1);
        wait_q(1, exp_q(1'b1, 1'b0), 60);
        drive_mv(1, 19'h15F90);
        wait_q(1, exp_q(1'b1, 1'b1), 60);
        drive_mv(1, 19'h11170);
        hold_q(1, 1'b0, 100);
        drive_mv(1, 19'h0C350);
        wait_q(1, 1'b1, 60);
        rdchk("count nc", ra(1, OFS_COUNT), 32'h2);
        // a glitch shorter than the delay must leave no trace
        apb(1'b1, ra(2, OFS_ACT_DLY), 32'hC);
        drive_mv(2, 19'h15F90);
        repeat (5 * MSC + 2) @(posedge pclk);
        drive_mv(2, 19'h0C350);
        hold_q(2, 1'b0, 200);
        drive_mv(2, 19'h15F90);
        wait_q(2, 1'b1, 300);
        chk_rng("act delay", 12 * MSC - 4, 5 * MSC + 13 * MSC + 8);
        apb(1'b1, ra(4, OFS_DROP_DLY), 32'h6);
        drive_mv(4, 19'h15F90);
        wait_q(4, 1'b1, 60);
        drive_mv(4, 19'h0C350);
        wait_q(4, 1'b0, 300);
        chk_rng("drop delay", 6 * MSC - 4, 5 * MSC + 7 * MSC + 8);
        apb(1'b1, ra(3, OFS_CFG), 32'h2);
        drive_mv(3, 19'h15F90);
        wait_q(3, 1'b1, 60);
        drive_mv(3, 19'h02260);
        hold_q(3, 1'b1, 150);
        drive_mv(3, 19'h0225F);
        wait_q(3, 1'b0, 400);
        chk_rng("ac drop", 30 * MSC - 4, 5 * MSC + 31 * MSC + 8);
        rdchk("status no", ra(0, OFS_STATUS), 32'h3);
        rdchk("status nc", ra(1, OFS_STATUS), 32'h1);
        rdchk("status ac", ra(3, OFS_STATUS), 32'h0);
        apb(1'b0, ra(7, OFS_STATUS), 32'h0);
        rdchk("all state", OFS_ALL_STATE, {24'h0, rd[0], 7'h07});
        chk_eq("pslverr mapped", 32'h0, {31'h0, er});
        print_verdict();
    end
endmodule : tb_top
